// file: hdl/idst_top.sv
// Data, status, bit-rate and time-out part of a two-wire serial bus master.
// Assumes a classic Wishbone master on clk_i and open-drain pads resolved outside.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "idst_defs.svh"

module idst_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire idst_pkg::idst_wb_req_s wb_req_i,
    output idst_pkg::idst_wb_rsp_s wb_rsp_o,
    input wire logic scl_i,
    input wire logic sda_i,
    output idst_pkg::idst_pin_out_s pins_o,
    output logic irq_o
);

    localparam logic [7:0] TOC_RST = `IDST_TOC_RESET;

    idst_pkg::idst_state_s s_reg;
    idst_pkg::idst_state_s s_next;
    logic to_ovf;

    assign wb_rsp_o = s_reg.rsp;
    assign pins_o = s_reg.pins;
    assign irq_o = s_reg.irq;

    function automatic logic [4:0] done_code(input logic addr_phase, input logic rd,
                                              input logic ack);
        logic [4:0] c;
        if (addr_phase) begin
            c = rd ? (ack ? `IDST_CODE_AR_ACK : `IDST_CODE_AR_NACK)
                   : (ack ? `IDST_CODE_AW_ACK : `IDST_CODE_AW_NACK);
        end else begin
            c = rd ? (ack ? `IDST_CODE_DR_ACK : `IDST_CODE_DR_NACK)
                   : (ack ? `IDST_CODE_DW_ACK : `IDST_CODE_DW_NACK);
        end
        return c;
    endfunction

    idst_timeout #(
        .WIDTH(`IDST_TO_WIDTH)
    ) u_timeout (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(s_reg.evt && s_reg.to_en),
        .div4_i(s_reg.to_div),
        .ovf_o(to_ovf)
    );

    always_comb begin
        logic acc;
        logic wr;
        logic [7:0] wdat;
        logic [7:0] rdat;
        logic tick;
        logic advance;
        logic evt_set;
        logic [4:0] code;
        logic rx_data;
        acc = 1'b0;
        wr = 1'b0;
        wdat = 8'h00;
        rdat = 8'h00;
        tick = 1'b0;
        advance = 1'b0;
        evt_set = 1'b0;
        code = `IDST_CODE_IDLE;
        rx_data = 1'b0;
        s_next = s_reg;

        // Pad inputs: a level is accepted only once the last two stages agree.
        s_next.scl_sync = {s_reg.scl_sync[1:0], scl_i};
        s_next.sda_sync = {s_reg.sda_sync[1:0], sda_i};
        if (s_reg.scl_sync[1] == s_reg.scl_sync[2]) begin
            s_next.scl_f = s_reg.scl_sync[2];
        end
        if (s_reg.sda_sync[1] == s_reg.sda_sync[2]) begin
            s_next.sda_f = s_reg.sda_sync[2];
        end

        // Register access; hardware updates below take priority over these.
        acc = wb_req_i.cyc && wb_req_i.stb && !s_reg.rsp.ack;
        wr = acc && wb_req_i.we && wb_req_i.sel[0];
        wdat = wb_req_i.dat[7:0];
        case (wb_req_i.adr[11:2])
            `IDST_IDX_DATA: begin
                rdat = s_reg.data;
                if (wr) begin
                    s_next.data = wdat;
                end
            end
            `IDST_IDX_STAT: begin
                rdat = {s_reg.status, 3'b000};
            end
            `IDST_IDX_CLK: begin
                rdat = s_reg.clk_div;
                if (wr) begin
                    s_next.clk_div = wdat;
                end
            end
            `IDST_IDX_TOC: begin
                rdat = {TOC_RST[7:3], s_reg.to_en, s_reg.to_div, s_reg.to_flag};
                if (wr) begin
                    s_next.to_en = wdat[`IDST_TOC_EN_BIT];
                    s_next.to_div = wdat[`IDST_TOC_DIV_BIT];
                    if (!wdat[`IDST_TOC_FLAG_BIT]) begin
                        s_next.to_flag = 1'b0;
                    end
                end
            end
            `IDST_IDX_CTL: begin
                rdat = {1'b0, s_reg.ctl_en, s_reg.ctl_sta, s_reg.ctl_sto, s_reg.evt,
                        s_reg.ctl_aa, 2'b00};
                if (wr) begin
                    s_next.ctl_en = wdat[`IDST_CTL_EN_BIT];
                    s_next.ctl_sta = wdat[`IDST_CTL_STA_BIT];
                    s_next.ctl_sto = wdat[`IDST_CTL_STO_BIT];
                    s_next.ctl_aa = wdat[`IDST_CTL_AA_BIT];
                    if (!wdat[`IDST_CTL_EVT_BIT]) begin
                        s_next.evt = 1'b0;
                    end
                end
            end
            `IDST_IDX_ISTAT: begin
                rdat = {6'b000000, s_reg.irq_stat};
                if (wr) begin
                    s_next.irq_stat = s_reg.irq_stat & ~wdat[1:0];
                end
            end
            `IDST_IDX_IMASK: begin
                rdat = {6'b000000, s_reg.irq_mask};
                if (wr) begin
                    s_next.irq_mask = wdat[1:0];
                end
            end
            default: begin
                rdat = 8'h00;
            end
        endcase
        s_next.rsp.ack = acc;
        s_next.rsp.dat = acc ? {24'h000000, rdat} : 32'h00000000;

        // Quarter-period tick: four ticks of (divisor + 1) clocks per bit.
        tick = (s_reg.tick_cnt == s_reg.clk_div);
        s_next.tick_cnt = tick ? 8'h00 : s_reg.tick_cnt + 8'h01;
        // A slave stretching the clock stalls the high phase until the line rises.
        // The wait sits in the quarter after the release, where our own pull is gone.
        advance = tick && ((s_reg.quarter != 2'h2) || s_reg.scl_f);
        rx_data = s_reg.rd_mode && !s_reg.addr_phase;

        case (s_reg.eng)
            idst_pkg::IDST_IDLE: begin
                if (s_reg.ctl_en && s_reg.ctl_sta && !s_reg.evt) begin
                    s_next.eng = idst_pkg::IDST_START;
                    s_next.quarter = 2'h0;
                end
            end
            idst_pkg::IDST_HOLD: begin
                // While still master, the clock line stays driven low until software clears the flag; after a lost arbitration it is released.
                s_next.pins.scl_oe = s_reg.master;
                if (!s_reg.evt) begin
                    s_next.quarter = 2'h0;
                    s_next.bit_cnt = 4'h0;
                    if (!s_reg.master) begin
                        s_next.eng = idst_pkg::IDST_IDLE;
                    end else if (s_reg.ctl_sto) begin
                        s_next.eng = idst_pkg::IDST_STOP;
                    end else if (s_reg.ctl_sta) begin
                        s_next.eng = idst_pkg::IDST_START;
                    end else begin
                        s_next.eng = idst_pkg::IDST_BIT;
                    end
                end
            end
            idst_pkg::IDST_START: begin
                if (advance) begin
                    s_next.quarter = s_reg.quarter + 2'h1;
                    case (s_reg.quarter)
                        2'h0: s_next.pins.sda_oe = 1'b0;
                        2'h1: s_next.pins.scl_oe = 1'b0;
                        2'h2: s_next.pins.sda_oe = 1'b1;
                        default: begin
                            s_next.pins.scl_oe = 1'b1;
                            evt_set = 1'b1;
                            code = s_reg.master ? `IDST_CODE_RSTART : `IDST_CODE_START;
                            s_next.master = 1'b1;
                            s_next.addr_phase = 1'b1;
                            s_next.rd_mode = 1'b0;
                            s_next.eng = idst_pkg::IDST_HOLD;
                        end
                    endcase
                end
            end
            idst_pkg::IDST_STOP: begin
                if (advance) begin
                    s_next.quarter = s_reg.quarter + 2'h1;
                    case (s_reg.quarter)
                        2'h0: s_next.pins.sda_oe = 1'b1;
                        2'h1: s_next.pins.scl_oe = 1'b0;
                        2'h2: s_next.pins.sda_oe = 1'b0;
                        default: begin
                            s_next.master = 1'b0;
                            s_next.ctl_sto = 1'b0;
                            s_next.status = `IDST_CODE_IDLE;
                            s_next.eng = idst_pkg::IDST_IDLE;
                        end
                    endcase
                end
            end
            idst_pkg::IDST_BIT: begin
                if (advance) begin
                    s_next.quarter = s_reg.quarter + 2'h1;
                    case (s_reg.quarter)
                        2'h0: begin
                            if (s_reg.bit_cnt[3]) begin
                                s_next.pins.sda_oe = rx_data && s_reg.ctl_aa;
                            end else begin
                                s_next.pins.sda_oe = !rx_data && !s_reg.data[7];
                            end
                        end
                        2'h1: s_next.pins.scl_oe = 1'b0;
                        2'h2: begin
                            if (!s_reg.bit_cnt[3]) begin
                                // Shifted regardless of direction, so a lost
                                // arbitration leaves the bits seen so far at the low end.
                                s_next.data = {s_reg.data[6:0], s_reg.sda_f};
                                if (!rx_data && !s_reg.pins.sda_oe && !s_reg.sda_f) begin
                                    s_next.pins.sda_oe = 1'b0;
                                    s_next.pins.scl_oe = 1'b0;
                                    s_next.master = 1'b0;
                                    evt_set = 1'b1;
                                    code = `IDST_CODE_ARB_LOST;
                                    s_next.eng = idst_pkg::IDST_HOLD;
                                end
                            end
                        end
                        default: begin
                            s_next.pins.scl_oe = 1'b1;
                            if (s_reg.bit_cnt[3]) begin
                                evt_set = 1'b1;
                                code = done_code(s_reg.addr_phase,
                                                 s_reg.addr_phase ? s_reg.data[0]
                                                                  : s_reg.rd_mode,
                                                 !s_reg.sda_f);
                                if (s_reg.addr_phase) begin
                                    s_next.rd_mode = s_reg.data[0];
                                end
                                s_next.addr_phase = 1'b0;
                                s_next.pins.sda_oe = 1'b0;
                                s_next.eng = idst_pkg::IDST_HOLD;
                            end else begin
                                s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                            end
                        end
                    endcase
                end
            end
            default: begin
                s_next.eng = idst_pkg::IDST_IDLE;
            end
        endcase

        if (!s_reg.ctl_en) begin
            s_next.eng = idst_pkg::IDST_IDLE;
            s_next.master = 1'b0;
            s_next.pins.scl_oe = 1'b0;
            s_next.pins.sda_oe = 1'b0;
        end

        // Hardware sets win over a software clear in the same cycle.
        if (evt_set) begin
            s_next.evt = 1'b1;
            s_next.status = code;
            s_next.irq_stat[`IDST_IRQ_EVT_BIT] = 1'b1;
        end
        if (to_ovf) begin
            s_next.to_flag = 1'b1;
            s_next.irq_stat[`IDST_IRQ_TOF_BIT] = 1'b1;
        end
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.eng <= idst_pkg::IDST_IDLE;
            s_reg.data <= `IDST_DATA_RESET;
            s_reg.status <= `IDST_CODE_IDLE;
            s_reg.clk_div <= `IDST_CLK_RESET;
            s_reg.to_en <= TOC_RST[`IDST_TOC_EN_BIT];
            s_reg.to_div <= TOC_RST[`IDST_TOC_DIV_BIT];
            s_reg.to_flag <= TOC_RST[`IDST_TOC_FLAG_BIT];
            s_reg.scl_sync <= 3'b111;
            s_reg.sda_sync <= 3'b111;
            s_reg.scl_f <= 1'b1;
            s_reg.sda_f <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule
`default_nettype wire

// file: hdl/idst_defs.svh
// Constants for the two-wire data, status, bit-rate and time-out block.
// Assumes nothing beyond being included once by name from the package and design files.
`ifndef IDST_DEFS_SVH
`define IDST_DEFS_SVH

// Register indices; the Wishbone byte address is four times the index.
`define IDST_IDX_DATA 10'h0BC
`define IDST_IDX_STAT 10'h0BD
`define IDST_IDX_CLK 10'h0BE
`define IDST_IDX_TOC 10'h0BF
`define IDST_IDX_CTL 10'h0C0
`define IDST_IDX_ISTAT 10'h0C1
`define IDST_IDX_IMASK 10'h0C2

// Reset values.
`define IDST_DATA_RESET 8'h00
`define IDST_STAT_RESET 8'hF8
`define IDST_CLK_RESET 8'h09
`define IDST_TOC_RESET 8'h09

// Field positions in timeout_control.
`define IDST_TOC_EN_BIT 2
`define IDST_TOC_DIV_BIT 1
`define IDST_TOC_FLAG_BIT 0

// Field positions in the control register.
`define IDST_CTL_EN_BIT 6
`define IDST_CTL_STA_BIT 5
`define IDST_CTL_STO_BIT 4
`define IDST_CTL_EVT_BIT 3
`define IDST_CTL_AA_BIT 2

// Interrupt status and mask bit positions.
`define IDST_IRQ_EVT_BIT 0
`define IDST_IRQ_TOF_BIT 1

// Status codes held in bits 7:3.
`define IDST_CODE_IDLE 5'h1F
`define IDST_CODE_START 5'h01
`define IDST_CODE_RSTART 5'h02
`define IDST_CODE_AW_ACK 5'h03
`define IDST_CODE_AW_NACK 5'h04
`define IDST_CODE_DW_ACK 5'h05
`define IDST_CODE_DW_NACK 5'h06
`define IDST_CODE_ARB_LOST 5'h07
`define IDST_CODE_AR_ACK 5'h08
`define IDST_CODE_AR_NACK 5'h09
`define IDST_CODE_DR_ACK 5'h0A
`define IDST_CODE_DR_NACK 5'h0B

// Time-out counter width and prescale.
`define IDST_TO_WIDTH 14
`define IDST_TO_PRESCALE 2'h3

`endif

// file: hdl/idst_pkg.sv
// Types shared by the two-wire data, status and time-out block.
// Assumes idst_defs.svh is on the include path.
`include "idst_defs.svh"

package idst_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } idst_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } idst_wb_rsp_s;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } idst_pin_out_s;

    typedef enum logic [4:0] {
        IDST_IDLE = 5'b00001,
        IDST_START = 5'b00010,
        IDST_BIT = 5'b00100,
        IDST_HOLD = 5'b01000,
        IDST_STOP = 5'b10000
    } idst_eng_e;

    typedef struct packed {
        logic [1:0] pre;
        logic [`IDST_TO_WIDTH-1:0] cnt;
        logic ovf;
    } idst_to_state_s;

    typedef struct packed {
        idst_eng_e eng;
        logic [1:0] quarter;
        logic [7:0] tick_cnt;
        logic [3:0] bit_cnt;
        logic addr_phase;
        logic rd_mode;
        logic master;
        logic [7:0] data;
        logic [4:0] status;
        logic [7:0] clk_div;
        logic to_en;
        logic to_div;
        logic to_flag;
        logic ctl_en;
        logic ctl_sta;
        logic ctl_sto;
        logic ctl_aa;
        logic evt;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        idst_wb_rsp_s rsp;
        idst_pin_out_s pins;
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic scl_f;
        logic sda_f;
    } idst_state_s;

endpackage

// file: hdl/idst_timeout.sv
// Time-out counter: counts system clocks, or every fourth one, while run is high.
// Assumes run comes from logic on the same clock; overflow is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "idst_defs.svh"

module idst_timeout #(
    parameter int WIDTH = `IDST_TO_WIDTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic div4_i,
    output logic ovf_o
);

    idst_pkg::idst_to_state_s s_reg;
    idst_pkg::idst_to_state_s s_next;

    assign ovf_o = s_reg.ovf;

    always_comb begin
        logic step;
        step = 1'b0;
        s_next = s_reg;
        s_next.ovf = 1'b0;
        if (!run_i) begin
            // Clearing on stop restarts the full period for every new hold.
            s_next.pre = 2'h0;
            s_next.cnt = '0;
        end else begin
            s_next.pre = s_reg.pre + 2'h1;
            step = !div4_i || (s_reg.pre == `IDST_TO_PRESCALE);
            if (step) begin
                s_next.cnt = s_reg.cnt + {{(`IDST_TO_WIDTH-1){1'b0}}, 1'b1};
                s_next.ovf = &s_reg.cnt;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule
`default_nettype wire

// file: testbench/idst_assertions.sv
// Checker for the two-wire data, status and time-out block, bound to its top ports.
// Assumes single Wishbone cycles whose request stands until the ack cycle.
`timescale 1ns/1ps
`default_nettype none
`include "idst_defs.svh"
module idst_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire idst_pkg::idst_wb_req_s wb_req_i,
    input wire idst_pkg::idst_wb_rsp_s wb_rsp_o,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire idst_pkg::idst_pin_out_s pins_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd;
    logic wr;
    logic [9:0] idx;
    logic evt_reg;
    logic hold_reg;
    logic [7:0] last_reg;
    assign idx = wb_req_i.adr[11:2];
    assign rd = wb_rsp_o.ack && !wb_req_i.we;
    assign wr = wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel[0];
    // The event flag is tracked as software last read it; any control write forgets it,
    // which only narrows what is checked.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_reg <= 1'b0;
            hold_reg <= 1'b0;
            last_reg <= 8'h00;
        end else if (wr && (idx == `IDST_IDX_CTL || idx == `IDST_IDX_DATA)) begin
            evt_reg <= evt_reg && idx == `IDST_IDX_DATA;
            hold_reg <= 1'b0;
        end else if (rd && idx == `IDST_IDX_CTL) begin
            evt_reg <= wb_rsp_o.dat[`IDST_CTL_EVT_BIT];
        end else if (rd && idx == `IDST_IDX_DATA) begin
            hold_reg <= evt_reg;
            last_reg <= wb_rsp_o.dat[7:0];
        end
    end
    AST_ACK_PULSE:
        assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack held too long");
    AST_ACK_TIME:
        assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("request not answered next cycle");
    AST_STAT_ZERO:
        assert property (rd && idx == `IDST_IDX_STAT |-> wb_rsp_o.dat[2:0] == 3'h0)
        else $error("status low bits not zero");
    AST_STAT_CODE:
        assert property (rd && idx == `IDST_IDX_STAT
            |-> wb_rsp_o.dat[7:3] inside {[5'h01:5'h0B], 5'h1F})
        else $error("status code outside the set");
    AST_DATA_HOLD:
        assert property (rd && idx == `IDST_IDX_DATA && hold_reg |-> wb_rsp_o.dat[7:0] == last_reg)
        else $error("data byte changed while event flag set");
    AST_SCL_HELD:
        assert property (evt_reg |-> pins_o.scl_oe) else $error("clock line released");
    AST_MASK_OFF:
        assert property (wr && idx == `IDST_IDX_IMASK && wb_req_i.dat[1:0] == 2'h0
            |-> ##[1:3] !irq_o) else $error("interrupt stays with mask clear");
    AST_IRQ_CLEAR:
        assert property (wr && idx == `IDST_IDX_ISTAT && wb_req_i.dat[1:0] == 2'h3
            |-> ##[1:3] !irq_o) else $error("interrupt stays after clear");
    AST_RESET_OUT:
        assert property ($fell(rst_i) |-> !wb_rsp_o.ack && !pins_o.scl_oe && !pins_o.sda_oe
            && !irq_o) else $error("outputs active after reset");
    COV_ACKED: cover property (rd && idx == `IDST_IDX_STAT && wb_rsp_o.dat[7:3] == 5'h05);
    COV_IRQ: cover property ($rose(irq_o));
    COV_HELD: cover property (rd && idx == `IDST_IDX_DATA && hold_reg);
endmodule
bind idst_top idst_assertions idst_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .scl_i(scl_i), .sda_i(sda_i),
    .pins_o(pins_o), .irq_o(irq_o));
`default_nettype wire

// file: testbench/idst_slave_model.sv
// Behavioural two-wire slave: acknowledges each byte unless told not to, may stretch.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module idst_slave_model (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic nack_i,
    input wire logic stretch_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    int bits = 0;
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // A start condition begins a new byte.
    always @(negedge sda_i) begin
        if (scl_i === 1'b1) begin
            bits = 0;
        end
    end
    always @(posedge scl_i) begin
        bits = bits + 1;
    end
    // The acknowledge goes out after the eighth bit and is withdrawn after the ninth.
    always @(negedge scl_i) begin
        sda_oe_o <= (bits == 8) && !nack_i;
        if (bits >= 9) begin
            bits = 0;
        end
        if (stretch_i) begin
            scl_oe_o <= 1'b1;
            #300 scl_oe_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: testbench/idst_top_tb_top.sv
// Self-checking bench for the two-wire data, status and time-out block.
// Assumes the slave model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "idst_defs.svh"
module idst_top_tb_top;
    localparam logic [11:0] A_DAT = {`IDST_IDX_DATA, 2'h0};
    localparam logic [11:0] A_STA = {`IDST_IDX_STAT, 2'h0};
    localparam logic [11:0] A_CLK = {`IDST_IDX_CLK, 2'h0};
    localparam logic [11:0] A_TOC = {`IDST_IDX_TOC, 2'h0};
    localparam logic [11:0] A_CTL = {`IDST_IDX_CTL, 2'h0};
    localparam logic [11:0] A_IST = {`IDST_IDX_ISTAT, 2'h0};
    localparam logic [11:0] A_MSK = {`IDST_IDX_IMASK, 2'h0};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    idst_pkg::idst_wb_req_s req = '0;
    idst_pkg::idst_wb_rsp_s rsp;
    idst_pkg::idst_pin_out_s pins;
    logic irq;
    logic s_scl_oe;
    logic s_sda_oe;
    logic nack = 1'b0;
    logic stretch = 1'b0;
    logic [7:0] rd;
    logic [7:0] tx [3] = '{8'hA4, 8'h3C, 8'h5A};
    logic [7:0] code [3] = '{8'h18, 8'h28, 8'h30};
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    int t0 = 0;
    int last_rise = 0;
    int period = 0;
    wire logic scl = !(pins.scl_oe === 1'b1 || s_scl_oe);
    wire logic sda = !(pins.sda_oe === 1'b1 || s_sda_oe);
    idst_top idst_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .scl_i(scl), .sda_i(sda), .pins_o(pins), .irq_o(irq));
    idst_slave_model idst_slave_model_i (.scl_i(scl), .sda_i(sda), .nack_i(nack),
        .stretch_i(stretch), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe));
    initial begin
        forever #5 clk_i = !clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
    end
    // Spacing of successive clock-line pulls gives the serial bit period.
    always @(posedge pins.scl_oe) begin
        period = cyc - last_rise;
        last_rise = cyc;
    end
    task automatic wrap_up();
        $display("counts: %0d checked, %0d errors", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h0, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 16);
        if (rsp.ack !== 1'b1) begin
            errors++;
            $display("mismatch ack expected 1 seen 0");
            wrap_up();
        end
        rd = rsp.dat[7:0];
        req <= '0;
    endtask
    task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        cmp(what, exp, rd);
    endtask
    task automatic poll(input logic [11:0] a, input logic [7:0] m, input logic [7:0] v,
                        input int lim);
        int n;
        n = 0;
        do begin
            wb(1'b0, a, 8'h00);
            n++;
        end while ((rd & m) !== v && n < lim);
        if ((rd & m) !== v) begin
            errors++;
            $display("mismatch poll %h expected %h seen %h", a, v, rd & m);
            wrap_up();
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk("data reset", A_DAT, `IDST_DATA_RESET);
        rchk("status reset", A_STA, `IDST_STAT_RESET);
        rchk("divisor reset", A_CLK, `IDST_CLK_RESET);
        rchk("timeout reset", A_TOC, `IDST_TOC_RESET);
        rchk("event idle", A_CTL, 8'h00);
        wb(1'b1, A_STA, 8'h00);
        rchk("status read only", A_STA, 8'hF8);
        wb(1'b1, 12'h7F0, 8'h5A);
        rchk("unmapped", 12'h7F0, 8'h00);
        wb(1'b1, A_DAT, 8'hC3);
        rchk("data written", A_DAT, 8'hC3);
        $display("test registers done");
        wb(1'b1, A_CLK, 8'h04);
        wb(1'b1, A_TOC, 8'h00);
        wb(1'b1, A_CTL, 8'h60);
        poll(A_CTL, 8'h08, 8'h08, 400);
        rchk("start code", A_STA, 8'h08);
        cmp("irq masked", 8'h00, {7'h0, irq});
        wb(1'b1, A_MSK, 8'h03);
        repeat (2) @(posedge clk_i);
        cmp("irq raised", 8'h01, {7'h0, irq});
        wb(1'b1, A_IST, 8'h01);
        repeat (2) @(posedge clk_i);
        cmp("irq cleared", 8'h00, {7'h0, irq});
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, A_DAT, tx[i]);
            rchk("data to send", A_DAT, tx[i]);
            nack <= (i == 2);
            stretch <= (i == 1);
            wb(1'b1, A_CTL, 8'h44);
            poll(A_CTL, 8'h08, 8'h08, 400);
            rchk("byte code", A_STA, code[i]);
            rchk("bus byte", A_DAT, tx[i]);
            cmp("clock held", 8'h01, {7'h0, pins.scl_oe});
            rchk("data held", A_DAT, tx[i]);
            if (i == 0) begin
                cmp("bit period", 8'h01, {7'h0, (period >= 20 && period <= 26)});
            end
        end
        wb(1'b1, A_CTL, 8'h50);
        poll(A_STA, 8'hFF, 8'hF8, 400);
        rchk("no event at idle", A_CTL, 8'h40);
        $display("test transfer done");
        wb(1'b1, A_CTL, 8'h60);
        poll(A_CTL, 8'h08, 8'h08, 400);
        wb(1'b1, A_IST, 8'h03);
        wb(1'b1, A_TOC, 8'h04);
        t0 = cyc;
        poll(A_TOC, 8'h01, 8'h01, 6000);
        cmp("overflow at full rate", 8'h01,
            {7'h0, (cyc - t0 >= 16382 && cyc - t0 <= 16396)});
        cmp("timeout irq", 8'h01, {7'h0, irq});
        repeat (300) @(posedge clk_i);
        rchk("flag kept", A_TOC, 8'h0D);
        wb(1'b1, A_TOC, 8'h00);
        wb(1'b1, A_TOC, 8'h06);
        t0 = cyc;
        poll(A_TOC, 8'h01, 8'h01, 23000);
        cmp("overflow at quarter rate", 8'h01,
            {7'h0, (cyc - t0 >= 65528 && cyc - t0 <= 65560)});
        wb(1'b1, A_MSK, 8'h00);
        repeat (2) @(posedge clk_i);
        cmp("irq masked off", 8'h00, {7'h0, irq});
        $display("test timeout done");
        wrap_up();
    end
endmodule
`default_nettype wire
